// >>> design/rbas_reg.sv
// Functional notes
// - Read-only bits ignore writes, read current value.
// - Clear-on-read returns content, then clears; writes ignored.
// - Write-only bits store writes; readback undefined.
// - Writing one clears; writing zero keeps value.
// - Latch-low holds low until read.
// - Sticky-high holds high until read.
// - Auto-clearing bit drops itself; zero writes ignored.
`timescale 1ns/100ps
`default_nettype none
`include "rbas_cfg.svh"

// ==========================================================================
// Generic register with per-bit access kinds.
// ==========================================================================

module rbas_reg
  import rbas_pkg::*;
#(
  parameter int WIDTH = `RBAS_WIDTH,
  parameter logic [`RBAS_ACC_BITS*WIDTH-1:0] ACC_MAP = `RBAS_ACC_MAP,
  parameter logic [WIDTH-1:0] RST_VAL = `RBAS_RST_VAL
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_sel,
  input wire logic i_rd_stb,
  input wire logic i_wr_stb,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [WIDTH-1:0] i_hw,
  output logic [WIDTH-1:0] o_rdata,
  output logic o_rvalid,
  output logic [WIDTH-1:0] o_bits
);

  // ========================================================================
  // Access decode helpers.
  // ========================================================================

  // Kind of bit n taken from the packed map.
  function automatic rbas_acc_t rbas_kind(input int n);
    rbas_kind = rbas_acc_t'(ACC_MAP[`RBAS_ACC_BITS*n +: `RBAS_ACC_BITS]);
  endfunction

  // Write-only and reserved bits read back as zero.
  function automatic logic rbas_readable(input rbas_acc_t k);
    rbas_readable = (k != RBAS_WO) && (k != RBAS_RSVD);
  endfunction

  logic rd_hit;
  logic wr_hit;
  logic [WIDTH-1:0] q;
  logic [WIDTH-1:0] rdata_d;

  // Only a strobe addressed to this register counts, so that a read of
  // a neighbour never clears or releases anything here.
  assign rd_hit = i_rd_stb & i_sel;
  assign wr_hit = i_wr_stb & i_sel;

  // ========================================================================
  // Bit cells.
  // ========================================================================

  // One cell per bit; reserved bits drop writes, so a careless write of
  // ones there is harmless even though software should write zeros.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_bit
      rbas_bit #(
        .ACC(rbas_kind(gi)),
        .RST(RST_VAL[gi])
      ) u_bit (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_rd(rd_hit),
        .i_wr(wr_hit),
        .i_wbit(i_wdata[gi]),
        .i_hw(i_hw[gi]),
        .o_q(q[gi])
      );
      // Read value masks the bits whose readback carries no meaning.
      assign rdata_d[gi] = rbas_readable(rbas_kind(gi)) ? q[gi] : 1'b0;
    end
  endgenerate

  // ========================================================================
  // Read return path.
  // ========================================================================

  // Read data captures the value before the side effect of the same read
  // lands, which is why a cleared bit still reports its old content.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rdata <= '0;
    end
    else if (rd_hit)
    begin
      o_rdata <= rdata_d;
    end
  end

  // Answer marker, one cycle after the accepted read.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= rd_hit;
    end
  end

  // Bit values toward the block's own logic, registered once more so the
  // outputs come from flops of this module.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_bits <= RST_VAL;
    end
    else
    begin
      o_bits <= q;
    end
  end

  // ========================================================================
  // Checks.
  // ========================================================================

  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (!i_reset_n);

  sequence s_rd;
    rd_hit;
  endsequence

  sequence s_idle;
    !rd_hit && !wr_hit;
  endsequence

  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_chk
      if (rbas_kind(gi) == RBAS_RO)
      begin : g_ro
        AST_RO_LIVE_READ:
          assert property (s_rd |=> o_rdata[gi] == $past(i_hw[gi], 2))
          else $error("read-only bit returned a stale value");
      end
      else if (rbas_kind(gi) == RBAS_CLEAR_ON_READ)
      begin : g_cor
        AST_COR_READ_CLEARS:
          assert property (s_rd ##0 !i_hw[gi] |=> !q[gi])
          else $error("clear-on-read bit not cleared by read");
        AST_COR_RETURNS_OLD:
          assert property (s_rd |=> o_rdata[gi] == $past(q[gi]))
          else $error("clear-on-read bit returned wrong content");
        AST_COR_HOLDS:
          assert property (q[gi] && !rd_hit |=> q[gi])
          else $error("clear-on-read bit lost without addressed read");
        AST_COR_SET_WINS:
          assert property (i_hw[gi] |=> q[gi])
          else $error("event lost while clearing");
      end
      else if (rbas_kind(gi) == RBAS_WO)
      begin : g_wo
        AST_WO_STORES:
          assert property (wr_hit |=> ##1 o_bits[gi] == $past(i_wdata[gi], 2))
          else $error("write-only bit did not store value");
      end
      else if (rbas_kind(gi) == RBAS_WRITE_ONE_CLEAR)
      begin : g_w1c
        AST_W1C_ONE_CLEARS:
          assert property (wr_hit && i_wdata[gi] && !i_hw[gi] |=> !q[gi])
          else $error("write of one did not clear bit");
        AST_W1C_ZERO_KEEPS:
          assert property (q[gi] && !(wr_hit && i_wdata[gi]) |=> q[gi])
          else $error("bit cleared without a write of one");
      end
      else if (rbas_kind(gi) == RBAS_LATCH_LOW_STATUS)
      begin : g_latch_low
        AST_LATCH_LOW_HOLDS:
          assert property (!q[gi] && !rd_hit |=> !q[gi] [*1] ##0 !q[gi])
          else $error("latched low bit rose before a read");
        AST_LATCH_LOW_RELEASE:
          assert property (s_rd ##0 i_hw[gi] |=> q[gi])
          else $error("latched low bit not released by read");
      end
      else if (rbas_kind(gi) == RBAS_STICKY_HIGH_STATUS)
      begin : g_sticky
        AST_STICKY_HOLDS:
          assert property (q[gi] && !rd_hit ##1 s_idle |-> q[gi])
          else $error("sticky high bit fell before a read");
        AST_STICKY_RELEASE:
          assert property (s_rd ##0 !i_hw[gi] |=> !q[gi])
          else $error("sticky high bit not released by read");
      end
      else if (rbas_kind(gi) == RBAS_AUTO_CLEARING_BIT)
      begin : g_auto
        AST_AUTO_PULSE:
          assert property (wr_hit && i_wdata[gi] |=> q[gi] ##1
            (!q[gi] || $past(wr_hit && i_wdata[gi])))
          else $error("auto-clearing bit did not pulse once");
        AST_AUTO_ZERO_IDLE:
          assert property (!(wr_hit && i_wdata[gi]) |=> !q[gi])
          else $error("auto-clearing bit set without a write of one");
      end
      else if (rbas_kind(gi) == RBAS_RSVD)
      begin : g_rsv
        AST_RSV_ZERO:
          assert property (s_rd |=> !o_rdata[gi])
          else $error("reserved bit read back nonzero");
      end
    end
  endgenerate

endmodule

`default_nettype wire

// >>> common/rbas_cfg.svh
`ifndef RBAS_CFG_SVH
`define RBAS_CFG_SVH

// ==========================================================================
// Register geometry and reset values.
// ==========================================================================

// Number of bits held by one register.
`define RBAS_WIDTH 16

// Reset value of the stored bits.
`define RBAS_RST_VAL 16'h0000

// Access kind per bit, one nibble per bit, bit 0 in the lowest nibble.
// Encodings follow rbas_acc_t in the package.
`define RBAS_ACC_MAP 64'h6543_2108_7654_3210

// Width of one access-kind field inside the map.
`define RBAS_ACC_BITS 4

// ==========================================================================
// Read timing.
// ==========================================================================

// Cycles from an accepted read strobe to valid read data.
`define RBAS_RD_LAT 1

`endif

// >>> common/rbas_pkg.sv
`default_nettype none

package rbas_pkg;

  // ========================================================================
  // Access kinds of one register bit.
  // ========================================================================

  // Software-visible behaviour of a single bit.
  typedef enum logic [3:0]
  {
    RBAS_RW = 4'h0,
    RBAS_RO = 4'h1,
    RBAS_CLEAR_ON_READ = 4'h2,
    RBAS_WO = 4'h3,
    RBAS_WRITE_ONE_CLEAR = 4'h4,
    RBAS_LATCH_LOW_STATUS = 4'h5,
    RBAS_STICKY_HIGH_STATUS = 4'h6,
    RBAS_AUTO_CLEARING_BIT = 4'h7,
    RBAS_RSVD = 4'h8
  } rbas_acc_t;

endpackage

`default_nettype wire

// >>> design/rbas_bit.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// One register bit with a fixed access kind.
// ==========================================================================

module rbas_bit
  import rbas_pkg::*;
#(
  parameter rbas_acc_t ACC = RBAS_RW,
  parameter logic RST = 1'b0
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_wbit,
  input wire logic i_hw,
  output logic o_q
);

  logic q_d;

  // Next value by access kind; in the clear-on-read, write-one-clear and sticky-high kinds a hardware set beats a clear.
  always_comb
  begin
    q_d = o_q;
    case (ACC)
      RBAS_RW: q_d = i_wr ? i_wbit : o_q;
      RBAS_RO: q_d = i_hw;
      RBAS_CLEAR_ON_READ: q_d = i_hw | (o_q & ~i_rd);
      RBAS_WO: q_d = i_wr ? i_wbit : o_q;
      RBAS_WRITE_ONE_CLEAR: q_d = i_hw | (o_q & ~(i_wr & i_wbit));
      RBAS_LATCH_LOW_STATUS: q_d = i_rd ? i_hw : (o_q & i_hw);
      RBAS_STICKY_HIGH_STATUS: q_d = i_rd ? i_hw : (o_q | i_hw);
      RBAS_AUTO_CLEARING_BIT: q_d = i_wr & i_wbit;
      RBAS_RSVD: q_d = 1'b0;
      default: q_d = o_q;
    endcase
  end

  // Stored bit; the output is this flop directly.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_q <= RST;
    end
    else
    begin
      o_q <= q_d;
    end
  end

endmodule

`default_nettype wire

// >>> verification/rbas_tb.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Self-checking bench for the generic register.
// ==========================================================================

module tb
  import rbas_pkg::*;
;
  typedef struct packed
  {
    logic [15:0] hw;
    logic wen;
    logic [15:0] wd;
    logic [15:0] exp;
  } rbas_row_t;

  // Write-only and reserved bits carry no defined read value.
  localparam logic [15:0] RMASK = 16'heef7;

  logic i_clk, i_reset_n, i_sel, i_rd_stb, i_wr_stb, o_rvalid;
  logic [15:0] i_wdata, i_hw, o_rdata, o_bits, r;
  rbas_row_t rows [8];
  int errors, total_checks;

  rbas_reg dut_u
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_sel(i_sel),
    .i_rd_stb(i_rd_stb),
    .i_wr_stb(i_wr_stb),
    .i_wdata(i_wdata),
    .i_hw(i_hw),
    .o_rdata(o_rdata),
    .o_rvalid(o_rvalid),
    .o_bits(o_bits)
  );

  // The default map repeats bits 0..6 at bits 9..15, so one pattern fits both.
  function automatic logic [15:0] dup(input logic [6:0] v);
    // Bit 8 is reserved and is always written as zero here.
    return {v, 2'b00, v};
  endfunction

  // Free-running 20 MHz clock.
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ========================================================================
  // Compare, access and closing tasks.
  // ========================================================================

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
                          input logic [15:0] msk);
    total_checks++;
    if ((got & msk) !== (exp & msk))
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got & msk,
               exp & msk);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Condition inputs get two edges so registered cells see them.
  task automatic settle(input logic [15:0] hw);
    @(posedge i_clk);
    #1 i_hw = hw;
    repeat (2) @(posedge i_clk);
  endtask

  task automatic wr(input logic [15:0] d, input logic s);
    @(posedge i_clk);
    #1 i_sel = s;
    i_wr_stb = 1'b1;
    i_wdata = d;
    @(posedge i_clk);
    #1 i_sel = 1'b0;
    i_wr_stb = 1'b0;
    i_wdata = 16'h0000;
  endtask

  // A read answers with a one-cycle valid in the cycle after the strobe.
  task automatic rd(input logic s, output logic [15:0] q);
    @(posedge i_clk);
    #1 i_sel = s;
    i_rd_stb = 1'b1;
    @(posedge i_clk);
    #1 i_sel = 1'b0;
    i_rd_stb = 1'b0;
    q = o_rdata;
    chk_flag(o_rvalid, s);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog well beyond the fewer than one hundred cycles the tests need.
  initial
  begin
    #100000;
    errors++;
    print_verdict();
  end

  // ========================================================================
  // Main sequence.
  // ========================================================================

  initial
  begin
    i_reset_n = 1'b0;
    i_sel = 1'b0;
    i_rd_stb = 1'b0;
    i_wr_stb = 1'b0;
    i_wdata = 16'h0000;
    i_hw = 16'h0000;
    errors = 0;
    total_checks = 0;
    rows[0] = {dup(7'h76), 1'b0, 16'h0000, dup(7'h56)};
    rows[1] = {dup(7'h00), 1'b1, (dup(7'h23) | 16'h0080), dup(7'h55)};
    rows[2] = {dup(7'h00), 1'b1, dup(7'h10), dup(7'h00)};
    rows[3] = {dup(7'h20), 1'b0, 16'h0000, dup(7'h00)};
    rows[4] = {dup(7'h20), 1'b0, 16'h0000, dup(7'h20)};
    rows[5] = {dup(7'h40), 1'b0, 16'h0000, dup(7'h40)};
    rows[6] = {dup(7'h20), 1'b0, 16'h0000, dup(7'h40)};
    rows[7] = {dup(7'h20), 1'b0, 16'h0000, dup(7'h20)};
    repeat (2) @(posedge i_clk);
    #1 chk_word(o_bits, 16'h0000, 16'hffff);
    chk_word(o_rdata, 16'h0000, 16'hffff);
    chk_flag(o_rvalid, 1'b0);
    i_reset_n = 1'b1;
    foreach (rows[k])
    begin
      settle(rows[k].hw);
      if (rows[k].wen)
        wr(rows[k].wd, 1'b1);
      rd(1'b1, r);
      chk_word(r, rows[k].exp, RMASK);
    end
    // Unselected strobes and writes must not disturb a pending event.
    settle(dup(7'h04));
    settle(16'h0000);
    rd(1'b0, r);
    wr(dup(7'h01), 1'b0);
    wr(dup(7'h04), 1'b1);
    rd(1'b1, r);
    chk_word(r, dup(7'h04), RMASK);
    // The auto-clearing bit shows as a single-cycle pulse on the outputs.
    wr(16'h0080, 1'b1);
    @(posedge i_clk);
    #1 chk_flag(o_bits[7], 1'b1);
    @(posedge i_clk);
    #1 chk_flag(o_bits[7], 1'b0);
    // A reset in mid-run drops every stored bit at once.
    settle(dup(7'h40));
    #1 chk_word(o_bits, dup(7'h40), RMASK);
    i_reset_n = 1'b0;
    #1 chk_word(o_bits, 16'h0000, 16'hffff);
    chk_flag(o_rvalid, 1'b0);
    print_verdict();
  end
endmodule

`default_nettype wire
